// ---- hw/bsm_defs.svh ----
`ifndef BSM_DEFS_SVH
`define BSM_DEFS_SVH

// Reserved memory locations of the main channel.
`define BSM_MS_LO 16'h0808
`define BSM_MS_HI 16'h0809
`define BSM_MC_LO 16'h080A
`define BSM_MC_HI 16'h080B
`define BSM_MT_LO 16'h080C
`define BSM_MT_HI 16'h080D
// Reserved memory locations of the control channel.
`define BSM_CS_LO 16'h0848
`define BSM_CS_HI 16'h0849
`define BSM_CC_LO 16'h084A
`define BSM_CC_HI 16'h084B
`define BSM_CT_LO 16'h084C
`define BSM_CT_HI 16'h084D

// Device slot on the io_microprocessor.
`define BSM_DEV_SLOT 4'h1

// Main channel command bytes.
`define BSM_CMD_TX   8'h80
`define BSM_CMD_RX   8'h40

// Status byte and parameter byte fields.
`define BSM_ST_NBUSY  7
`define BSM_ST_ACC    6
`define BSM_ST_DSR    1
`define BSM_OFL_ASCII 7
`define BSM_OFL_DTR   4

// Line timing.
`define BSM_CLK_HZ   125000000
`define BSM_LINE_BPS 9600

`endif

// ---- hw/bsm_pkg.sv ----
package bsm_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_SEND  = 3'b010,
    ST_RECV  = 3'b011,
    ST_STORE = 3'b100,
    ST_SCAN  = 3'b101,
    ST_HOLD  = 3'b110
  } bsm_state_t;
endpackage

// ---- hw/bsm_lnk_if.sv ----
`timescale 1ns/10ps
`default_nettype none
interface bsm_lnk_if;
  logic       tx_en;
  logic       rx_en;
  logic       tx_valid;
  logic       tx_ready;
  logic [7:0] tx_byte;
  logic       rx_valid;
  logic [7:0] rx_byte;
  modport eng (output tx_en, rx_en, tx_valid, tx_byte, input tx_ready, rx_valid, rx_byte);
  modport ser (input tx_en, rx_en, tx_valid, tx_byte, output tx_ready, rx_valid, rx_byte);
endinterface
`default_nettype wire

// ---- hw/bsm_line_ser.sv ----
`timescale 1ns/10ps
`default_nettype none
module bsm_line_ser #(
  parameter int unsigned BIT_CYC = 13021
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  bsm_lnk_if.ser    ln,
  input  wire logic rxd_i,
  output logic      txd_o,
  output logic      rts_o
);
  localparam logic [15:0] DIV_LAST = 16'(BIT_CYC - 1);

  logic [15:0] div_r, div_nxt;
  logic        rxm_r, rxs_r;
  logic [7:0]  txsh_r, txsh_nxt, rxsh_r, rxsh_nxt;
  logic [3:0]  txcnt_r, txcnt_nxt;
  logic [2:0]  rxcnt_r, rxcnt_nxt;
  logic        rxv_r, rxv_nxt, txd_r, txd_nxt, rts_r, rts_nxt;
  logic        tick;

  assign tick        = (div_r == DIV_LAST);
  assign ln.tx_ready = ln.tx_en && ln.tx_valid && (txcnt_r == 4'h0);
  assign ln.rx_valid = rxv_r;
  assign ln.rx_byte  = rxsh_r;
  assign txd_o       = txd_r;
  assign rts_o       = rts_r;

  always_comb begin
    div_nxt   = tick ? 16'h0000 : div_r + 16'h0001;
    txsh_nxt  = txsh_r;
    txcnt_nxt = txcnt_r;
    txd_nxt   = txd_r;
    rxsh_nxt  = rxsh_r;
    rxcnt_nxt = rxcnt_r;
    rxv_nxt   = 1'b0;
    rts_nxt   = ln.tx_en;
    if (tick) begin
      if (txcnt_r != 4'h0) begin
        txd_nxt   = txsh_r[0];
        txsh_nxt  = {1'b0, txsh_r[7:1]};
        txcnt_nxt = txcnt_r - 4'h1;
      end else begin
        txd_nxt = 1'b1;
      end
    end
    if (ln.tx_ready) begin
      txsh_nxt  = ln.tx_byte;
      txcnt_nxt = 4'h8;
    end
    // Receive only while the engine listens; a byte already loaded still shifts out on txd, so it can overlap a receive.
    if (!ln.rx_en) begin
      rxcnt_nxt = 3'h0;
    end else if (tick) begin
      rxsh_nxt  = {rxs_r, rxsh_r[7:1]};
      rxcnt_nxt = rxcnt_r + 3'h1;
      rxv_nxt   = (rxcnt_r == 3'h7);
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      div_r   <= 16'h0000;
      rxm_r   <= 1'b1;
      rxs_r   <= 1'b1;
      txsh_r  <= 8'h00;
      txcnt_r <= 4'h0;
      rxsh_r  <= 8'h00;
      rxcnt_r <= 3'h0;
      rxv_r   <= 1'b0;
      txd_r   <= 1'b1;
      rts_r   <= 1'b0;
    end else begin
      div_r   <= div_nxt;
      rxm_r   <= rxd_i;
      rxs_r   <= rxm_r;
      txsh_r  <= txsh_nxt;
      txcnt_r <= txcnt_nxt;
      rxsh_r  <= rxsh_nxt;
      rxcnt_r <= rxcnt_nxt;
      rxv_r   <= rxv_nxt;
      txd_r   <= txd_nxt;
      rts_r   <= rts_nxt;
    end
  end

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  property p_bit_rate;
    $changed(txd_o) |-> $past(tick);
  endproperty
  a_bit_rate: assert property (p_bit_rate) else $error("line bit changed off the bit tick");

  // Listening must drop request to send, so the modem never keys the line while receiving.
  property p_one_direction;
    ln.rx_en |=> !rts_o;
  endproperty
  a_one_direction: assert property (p_one_direction) else $error("line keyed while receiving");
endmodule
`default_nettype wire

// ---- hw/bsm_main_channel.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bsm_defs.svh"
module bsm_main_channel #(
  parameter int unsigned BIT_CYC = (`BSM_CLK_HZ + `BSM_LINE_BPS - 1) / `BSM_LINE_BPS
) (
  input  wire logic       ref_clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       cpu_wr_i,
  input  wire logic [15:0] cpu_addr_i,
  input  wire logic [7:0] cpu_wdata_i,
  output logic [7:0]      cpu_rdata_o,
  input  wire logic       iob_sel_i,
  input  wire logic [3:0] iob_dev_i,
  input  wire logic       iob_com1_i,
  input  wire logic       iob_com2_i,
  input  wire logic       iob_dvcl_i,
  input  wire logic       iob_ofl_i,
  input  wire logic [7:0] iob_data_i,
  output logic [7:0]      iob_status_o,
  output logic            irq_o,
  output logic            mem_req_o,
  output logic            mem_we_o,
  output logic [15:0]     mem_addr_o,
  output logic [7:0]      mem_wdata_o,
  input  wire logic       mem_gnt_i,
  input  wire logic [7:0] mem_rdata_i,
  input  wire logic       rxd_i,
  input  wire logic       dsr_i,
  output logic            txd_o,
  output logic            rts_o,
  output logic            dtr_o
);
  bsm_pkg::bsm_state_t state_r, st_nxt;
  logic [15:0] start_r, start_nxt, term_r, term_nxt, cur_r, cur_nxt;
  logic [15:0] ls_r, ls_nxt, lt_r, lt_nxt, lc_r, lc_nxt, maddr_r, maddr_nxt;
  logic [7:0]  hold_r, hold_nxt, rd_r, rd_nxt, stat_r, stat_nxt;
  logic        sel_r, sel_nxt, busy_r, busy_nxt, acc_r, acc_nxt, irq_r, irq_nxt;
  logic        ascii_r, ascii_nxt, dtr_r, dtr_nxt, txm_r, txm_nxt;
  logic        req_r, req_nxt, we_r, we_nxt, dsrm_r, dsr_r, gnt, com1, com2, dvcl;

  bsm_lnk_if ln ();

  function automatic logic is_ctrl(input logic [7:0] b, input logic ascii);
    is_ctrl = ascii ? (b[6:5] == 2'b00) : (b[7:6] == 2'b00);
  endfunction

  assign gnt         = mem_gnt_i && req_r;
  assign com1        = sel_r && iob_com1_i;
  assign com2        = sel_r && iob_com2_i;
  assign dvcl        = sel_r && iob_dvcl_i;
  assign ln.tx_en    = busy_r && txm_r;
  assign ln.rx_en    = busy_r && !txm_r;
  assign ln.tx_valid = (state_r == bsm_pkg::ST_SEND);
  assign ln.tx_byte  = hold_r;
  assign cpu_rdata_o = rd_r;
  assign iob_status_o = stat_r;
  assign irq_o       = irq_r;
  assign mem_req_o   = req_r;
  assign mem_we_o    = we_r;
  assign mem_addr_o  = maddr_r;
  assign mem_wdata_o = hold_r;
  assign dtr_o       = dtr_r;

  always_comb begin
    st_nxt = state_r;
    start_nxt = start_r;
    term_nxt = term_r;
    cur_nxt = cur_r;
    ls_nxt = ls_r;
    lt_nxt = lt_r;
    lc_nxt = lc_r;
    maddr_nxt = maddr_r;
    hold_nxt = hold_r;
    sel_nxt = sel_r;
    busy_nxt = busy_r;
    acc_nxt = acc_r;
    irq_nxt = irq_r;
    ascii_nxt = ascii_r;
    dtr_nxt = dtr_r;
    txm_nxt = txm_r;
    req_nxt = gnt ? 1'b0 : req_r;
    we_nxt = we_r;
    // Reserved locations read back, current addresses included.
    case (cpu_addr_i)
      `BSM_MS_LO: rd_nxt = start_r[7:0];
      `BSM_MS_HI: rd_nxt = start_r[15:8];
      `BSM_MC_LO: rd_nxt = cur_r[7:0];
      `BSM_MC_HI: rd_nxt = cur_r[15:8];
      `BSM_MT_LO: rd_nxt = term_r[7:0];
      `BSM_MT_HI: rd_nxt = term_r[15:8];
      `BSM_CS_LO: rd_nxt = ls_r[7:0];
      `BSM_CS_HI: rd_nxt = ls_r[15:8];
      `BSM_CC_LO: rd_nxt = lc_r[7:0];
      `BSM_CC_HI: rd_nxt = lc_r[15:8];
      `BSM_CT_LO: rd_nxt = lt_r[7:0];
      `BSM_CT_HI: rd_nxt = lt_r[15:8];
      default:    rd_nxt = 8'h00;
    endcase
    if (cpu_wr_i) begin
      case (cpu_addr_i)
        `BSM_MS_LO: start_nxt[7:0] = cpu_wdata_i;
        `BSM_MS_HI: start_nxt[15:8] = cpu_wdata_i;
        `BSM_MT_LO: term_nxt[7:0] = cpu_wdata_i;
        `BSM_MT_HI: term_nxt[15:8] = cpu_wdata_i;
        `BSM_CS_LO: ls_nxt[7:0] = cpu_wdata_i;
        `BSM_CS_HI: ls_nxt[15:8] = cpu_wdata_i;
        `BSM_CT_LO: lt_nxt[7:0] = cpu_wdata_i;
        `BSM_CT_HI: lt_nxt[15:8] = cpu_wdata_i;
        default: ;
      endcase
    end
    if (iob_sel_i) begin
      sel_nxt = (iob_dev_i == `BSM_DEV_SLOT);
    end
    if (com1 || com2 || dvcl) begin
      irq_nxt = 1'b0;
      acc_nxt = 1'b0;
    end
    if (sel_r && iob_ofl_i) begin
      ascii_nxt = iob_data_i[`BSM_OFL_ASCII];
      dtr_nxt   = iob_data_i[`BSM_OFL_DTR];
    end
    case (state_r)
      bsm_pkg::ST_FETCH: begin
        if (!req_r) begin
          req_nxt = 1'b1;
          we_nxt = 1'b0;
          maddr_nxt = cur_r + 16'h0001;
        end else if (gnt) begin
          hold_nxt = mem_rdata_i;
          lc_nxt = ls_r;
          st_nxt = is_ctrl(mem_rdata_i, ascii_r) ? bsm_pkg::ST_SCAN : bsm_pkg::ST_SEND;
        end
      end
      bsm_pkg::ST_SEND: begin
        if (ln.tx_ready) begin
          cur_nxt = cur_r + 16'h0001;
          st_nxt = bsm_pkg::ST_FETCH;
          if (cur_r + 16'h0001 == term_r) begin
            busy_nxt = 1'b0;
            irq_nxt = 1'b1;
            st_nxt = bsm_pkg::ST_IDLE;
          end
        end
      end
      bsm_pkg::ST_RECV: begin
        if (ln.rx_valid) begin
          hold_nxt = ln.rx_byte;
          lc_nxt = ls_r;
          st_nxt = is_ctrl(ln.rx_byte, ascii_r) ? bsm_pkg::ST_SCAN : bsm_pkg::ST_STORE;
        end
      end
      bsm_pkg::ST_STORE: begin
        if (!req_r) begin
          req_nxt = 1'b1;
          we_nxt = 1'b1;
          maddr_nxt = cur_r + 16'h0001;
        end else if (gnt) begin
          cur_nxt = cur_r + 16'h0001;
          st_nxt = bsm_pkg::ST_RECV;
          if (cur_r + 16'h0001 == term_r) begin
            busy_nxt = 1'b0;
            irq_nxt = 1'b1;
            st_nxt = bsm_pkg::ST_IDLE;
          end
        end
      end
      bsm_pkg::ST_SCAN: begin
        if (!req_r && lc_r == lt_r) begin
          st_nxt = txm_r ? bsm_pkg::ST_SEND : bsm_pkg::ST_STORE;
        end else if (!req_r) begin
          req_nxt = 1'b1;
          we_nxt = 1'b0;
          maddr_nxt = lc_r + 16'h0001;
        end else if (gnt) begin
          lc_nxt = lc_r + 16'h0001;
          if (mem_rdata_i == hold_r) begin
            acc_nxt = 1'b1;
            irq_nxt = 1'b1;
            st_nxt = bsm_pkg::ST_HOLD;
          end
        end
      end
      bsm_pkg::ST_HOLD: begin
        // The matched character is passed on once the processor has answered.
        if (com2) begin
          st_nxt = txm_r ? bsm_pkg::ST_SEND : bsm_pkg::ST_STORE;
        end
      end
      default: st_nxt = bsm_pkg::ST_IDLE;
    endcase
    // Aborting drops a pending memory request; the arbiter must tolerate that.
    if (com1) begin
      req_nxt = 1'b0;
      cur_nxt = start_r;
      if (iob_data_i == `BSM_CMD_TX || iob_data_i == `BSM_CMD_RX) begin
        txm_nxt = (iob_data_i == `BSM_CMD_TX);
        busy_nxt = 1'b1;
        st_nxt = txm_nxt ? bsm_pkg::ST_FETCH : bsm_pkg::ST_RECV;
      end else begin
        busy_nxt = 1'b0;
        irq_nxt = 1'b1;
        st_nxt = bsm_pkg::ST_IDLE;
      end
    end
    if (dvcl) begin
      req_nxt = 1'b0;
      busy_nxt = 1'b0;
      ascii_nxt = 1'b0;
      dtr_nxt = 1'b0;
      st_nxt = bsm_pkg::ST_IDLE;
    end
    stat_nxt = 8'h00;
    stat_nxt[`BSM_ST_NBUSY] = !busy_nxt;
    stat_nxt[`BSM_ST_ACC] = acc_nxt;
    stat_nxt[`BSM_ST_DSR] = dsr_r;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_r <= bsm_pkg::ST_IDLE;
      start_r <= 16'h0000;
      term_r  <= 16'h0000;
      cur_r   <= 16'h0000;
      ls_r    <= 16'h0000;
      lt_r    <= 16'h0000;
      lc_r    <= 16'h0000;
      maddr_r <= 16'h0000;
      hold_r  <= 8'h00;
      rd_r    <= 8'h00;
      stat_r  <= 8'h80;
      sel_r   <= 1'b0;
      busy_r  <= 1'b0;
      acc_r   <= 1'b0;
      irq_r   <= 1'b0;
      ascii_r <= 1'b0;
      dtr_r   <= 1'b0;
      txm_r   <= 1'b0;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      dsrm_r  <= 1'b0;
      dsr_r   <= 1'b0;
    end else begin
      state_r <= st_nxt;
      start_r <= start_nxt;
      term_r  <= term_nxt;
      cur_r   <= cur_nxt;
      ls_r    <= ls_nxt;
      lt_r    <= lt_nxt;
      lc_r    <= lc_nxt;
      maddr_r <= maddr_nxt;
      hold_r  <= hold_nxt;
      rd_r    <= rd_nxt;
      stat_r  <= stat_nxt;
      sel_r   <= sel_nxt;
      busy_r  <= busy_nxt;
      acc_r   <= acc_nxt;
      irq_r   <= irq_nxt;
      ascii_r <= ascii_nxt;
      dtr_r   <= dtr_nxt;
      txm_r   <= txm_nxt;
      req_r   <= req_nxt;
      we_r    <= we_nxt;
      dsrm_r  <= dsr_i;
      dsr_r   <= dsrm_r;
    end
  end

  bsm_line_ser #(.BIT_CYC(BIT_CYC)) u_ser (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .ln        (ln),
    .rxd_i     (rxd_i),
    .txd_o     (txd_o),
    .rts_o     (rts_o)
  );

  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence s_list_hit;
    state_r == bsm_pkg::ST_SCAN && gnt && mem_rdata_i == hold_r && !com1 && !dvcl;
  endsequence
  property p_match_irq;
    s_list_hit |=> state_r == bsm_pkg::ST_HOLD && irq_o ##1 iob_status_o[`BSM_ST_ACC];
  endproperty
  a_match_irq: assert property (p_match_irq) else $error("list match not flagged");
  property p_done_irq;
    state_r == bsm_pkg::ST_SEND && ln.tx_ready && cur_r + 16'h0001 == term_r && !com1 && !dvcl
      |=> irq_o && state_r == bsm_pkg::ST_IDLE ##1 iob_status_o[`BSM_ST_NBUSY];
  endproperty
  a_done_irq: assert property (p_done_irq) else $error("terminating address did not finish");
  property p_fetch_addr;
    state_r == bsm_pkg::ST_FETCH && mem_req_o |-> mem_addr_o == cur_r + 16'h0001 && !mem_we_o;
  endproperty
  a_fetch_addr: assert property (p_fetch_addr) else $error("fetch not at current plus one");
  property p_store_step;
    state_r == bsm_pkg::ST_STORE && gnt && !com1 && !dvcl
      |-> mem_we_o ##1 cur_r == $past(mem_addr_o);
  endproperty
  a_store_step: assert property (p_store_step) else $error("current not last stored");
  property p_start_init;
    com1 && !dvcl && iob_data_i == `BSM_CMD_TX |=> cur_r == $past(start_r);
  endproperty
  a_start_init: assert property (p_start_init) else $error("current not loaded from start");
  property p_list_first;
    state_r == bsm_pkg::ST_FETCH && gnt && is_ctrl(mem_rdata_i, ascii_r) && !com1 && !dvcl
      |=> state_r == bsm_pkg::ST_SCAN ##[1:2] (mem_req_o && mem_addr_o == ls_r + 16'h0001)
      or lc_r == lt_r;
  endproperty
  a_list_first: assert property (p_list_first) else $error("list scan not from start plus one");
  property p_param_write;
    cpu_wr_i && cpu_addr_i == `BSM_MS_LO |=> start_r[7:0] == $past(cpu_wdata_i);
  endproperty
  a_param_write: assert property (p_param_write) else $error("start low not stored");
  property p_readback;
    cpu_addr_i == `BSM_MC_HI |=> cpu_rdata_o == $past(cur_r[15:8]);
  endproperty
  a_readback: assert property (p_readback) else $error("current high not readable");
  property p_mem_hold;
    mem_req_o && !mem_gnt_i && !com1 && !dvcl |=> mem_req_o && $stable(mem_addr_o);
  endproperty
  a_mem_hold: assert property (p_mem_hold) else $error("memory request dropped before grant");
endmodule
`default_nettype wire

// ---- testbench/bsm_modem_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module bsm_modem_model #(
  parameter int unsigned BIT_CYC = 4
) (
  input  wire logic ref_clk_i,
  input  wire logic rts_i,
  input  wire logic txd_i,
  output logic      rxd_o,
  output logic      dsr_o
);
  int unsigned rts_cycles;
  int unsigned tx_n;
  int unsigned tx_ph;
  logic [23:0] tx_bits;
  initial begin
    rxd_o = 1'b1;
    dsr_o = 1'b0;
    rts_cycles = 0;
    tx_n = 0;
    tx_ph = 0;
    tx_bits = 24'h000000;
  end
  // The first space bit while send is requested opens the frame; bits are then taken
  // once per bit time, half a clock after the line changes, for the first three bytes.
  always @(negedge ref_clk_i) begin
    if (tx_n == 0) begin
      if (rts_i === 1'b1 && txd_i === 1'b0) begin
        tx_bits <= {txd_i, tx_bits[23:1]};
        tx_n <= 1;
        tx_ph <= 1;
      end
    end else if (tx_n < 24) begin
      if (tx_ph == BIT_CYC) begin
        tx_bits <= {txd_i, tx_bits[23:1]};
        tx_n <= tx_n + 1;
        tx_ph <= 1;
      end else begin
        tx_ph <= tx_ph + 1;
      end
    end
  end
  // Counting send time lets the bench see that receive never keys the line.
  always @(posedge ref_clk_i) begin
    if (rts_i === 1'b1) rts_cycles++;
  end
  // Synchronous line, LSB first, two bytes back to back with no gap; mark follows.
  task automatic send(input logic [15:0] w);
    for (int i = 0; i < 16; i++) begin
      @(negedge ref_clk_i) rxd_o = w[i];
      repeat (BIT_CYC - 1) @(negedge ref_clk_i);
    end
    @(negedge ref_clk_i) rxd_o = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- testbench/bisync_main_channel_transfer_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "bsm_defs.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s expected %0h seen %0h", nm, e, g); end end
module bisync_main_channel_transfer_bench;
  logic        ref_clk_i, rst_b_i, cpu_wr_i, iob_sel_i, iob_com1_i, iob_com2_i;
  logic        iob_dvcl_i, iob_ofl_i, mem_gnt_i, rxd_i, dsr_i, irq_o, mem_req_o;
  logic        mem_we_o, txd_o, rts_o, dtr_o;
  logic [15:0] cpu_addr_i, mem_addr_o;
  logic [7:0]  cpu_wdata_i, cpu_rdata_o, iob_data_i, iob_status_o, mem_wdata_o;
  logic [7:0]  mem_rdata_i, rd;
  logic [3:0]  iob_dev_i;
  logic [7:0]  mem [0:65535];
  logic [15:0] rq [$];
  logic [23:0] wq [$];
  int          errors, n_tests, wt;
  int unsigned rc;

  bsm_main_channel #(.BIT_CYC(4)) i_bsm_main_channel (.ref_clk_i(ref_clk_i),
    .rst_b_i(rst_b_i), .cpu_wr_i(cpu_wr_i), .cpu_addr_i(cpu_addr_i),
    .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o), .iob_sel_i(iob_sel_i),
    .iob_dev_i(iob_dev_i), .iob_com1_i(iob_com1_i), .iob_com2_i(iob_com2_i),
    .iob_dvcl_i(iob_dvcl_i), .iob_ofl_i(iob_ofl_i), .iob_data_i(iob_data_i),
    .iob_status_o(iob_status_o), .irq_o(irq_o), .mem_req_o(mem_req_o),
    .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .mem_gnt_i(mem_gnt_i), .mem_rdata_i(mem_rdata_i), .rxd_i(rxd_i), .dsr_i(dsr_i),
    .txd_o(txd_o), .rts_o(rts_o), .dtr_o(dtr_o));
  bsm_modem_model #(.BIT_CYC(4)) i_bsm_modem_model (.ref_clk_i(ref_clk_i),
    .rts_i(rts_o), .txd_i(txd_o), .rxd_o(rxd_i), .dsr_o(dsr_i));

  initial begin
    ref_clk_i = 1'b0;
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  // Odd addresses are granted late so both prompt and stalled steals occur.
  always @(negedge ref_clk_i) begin
    mem_gnt_i <= 1'b0;
    mem_rdata_i <= ~mem_rdata_i;
    if (mem_req_o === 1'b1 && !mem_gnt_i) begin
      if (wt < (mem_addr_o[0] ? 2 : 0)) wt <= wt + 1;
      else begin
        wt <= 0;
        mem_gnt_i <= 1'b1;
        mem_rdata_i <= mem[mem_addr_o];
        if (mem_we_o) wq.push_back({mem_addr_o, mem_wdata_o});
        else rq.push_back(mem_addr_o);
      end
    end
  end

  task automatic finish_test;
    $display("errors %0d n_tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge ref_clk_i) {cpu_wr_i, cpu_addr_i, cpu_wdata_i} = {1'b1, a, d};
    @(negedge ref_clk_i) cpu_wr_i = 1'b0;
  endtask
  task automatic cpu_rd(input logic [15:0] a, output logic [7:0] d);
    @(negedge ref_clk_i) cpu_addr_i = a;
    @(negedge ref_clk_i) d = cpu_rdata_o;
  endtask
  task automatic set_area(input logic [15:0] b, input logic [15:0] s, input logic [15:0] t);
    cpu_wr(b, s[7:0]);
    cpu_wr(b + 16'h0001, s[15:8]);
    cpu_wr(b + 16'h0004, t[7:0]);
    cpu_wr(b + 16'h0005, t[15:8]);
  endtask
  // Kind: 0 select, 1 main command, 2 control resume, 3 stop, 4 parameters.
  task automatic iob(input int k, input logic [7:0] d);
    @(negedge ref_clk_i) begin
      iob_data_i = d;
      iob_dev_i = d[3:0];
      case (k)
        0: iob_sel_i = 1'b1;
        1: iob_com1_i = 1'b1;
        2: iob_com2_i = 1'b1;
        3: iob_dvcl_i = 1'b1;
        default: iob_ofl_i = 1'b1;
      endcase
    end
    @(negedge ref_clk_i) {iob_sel_i, iob_com1_i, iob_com2_i, iob_dvcl_i, iob_ofl_i} = '0;
    @(negedge ref_clk_i);
  endtask
  task automatic start_io(input logic [7:0] par, input logic [7:0] cmd);
    iob(0, 8'h01);
    iob(3, 8'h00);
    iob(4, par);
    rq.delete();
    wq.delete();
    iob(1, cmd);
  endtask
  task automatic wait_irq(input logic lvl);
    for (int i = 0; i < 3000; i++) begin
      @(negedge ref_clk_i);
      if (irq_o === lvl) return;
    end
    errors++;
    $display("BAD irq wait expected %0h seen %0h", lvl, irq_o);
    finish_test();
  endtask

  task automatic t_regs;
    `CHK("status", 8'h80, iob_status_o)
    `CHK("req", 1'b0, mem_req_o)
    `CHK("txd", 1'b1, txd_o)
    cpu_wr(`BSM_MS_LO, 8'h34);
    cpu_wr(`BSM_MS_HI, 8'h12);
    cpu_wr(`BSM_MC_LO, 8'h77);
    cpu_rd(`BSM_MS_LO, rd);
    `CHK("start lo", 8'h34, rd)
    cpu_rd(`BSM_MS_HI, rd);
    `CHK("start hi", 8'h12, rd)
    cpu_rd(`BSM_MC_LO, rd);
    `CHK("cur ro", 8'h00, rd)
    cpu_rd(16'h0810, rd);
    `CHK("unmapped", 8'h00, rd)
    i_bsm_modem_model.dsr_o = 1'b1;
    repeat (5) @(negedge ref_clk_i);
    `CHK("dsr bit", 1'b1, iob_status_o[`BSM_ST_DSR])
  endtask
  // EBCDIC: 85 is data, so no list scan happens; start low byte carries.
  // The first byte opens with a space bit so that the modem can frame the line.
  task automatic t_tx_plain;
    {mem[16'h1100], mem[16'h1101], mem[16'h1102], mem[16'h2001]} = 32'hC285C185;
    set_area(`BSM_MS_LO, 16'h10FF, 16'h1102);
    set_area(`BSM_CS_LO, 16'h2000, 16'h2001);
    rc = i_bsm_modem_model.rts_cycles;
    start_io(8'h10, `BSM_CMD_TX);
    `CHK("busy", 1'b0, iob_status_o[`BSM_ST_NBUSY])
    wait_irq(1'b1);
    `CHK("reads", 3, rq.size())
    `CHK("first", 16'h1100, rq[0])
    `CHK("last", 16'h1102, rq[2])
    `CHK("done", 8'h80, iob_status_o & 8'hC0)
    `CHK("dtr", 1'b1, dtr_o)
    `CHK("sent", 1'b1, i_bsm_modem_model.rts_cycles > rc)
    cpu_rd(`BSM_MC_LO, rd);
    `CHK("cur lo", 8'h02, rd)
    cpu_rd(`BSM_MC_HI, rd);
    `CHK("cur hi", 8'h11, rd)
    repeat (40) @(negedge ref_clk_i);
    `CHK("line", 24'hC185C2, i_bsm_modem_model.tx_bits)
  endtask
  // ASCII: 85 is a control byte found second in the list, then resumed.
  task automatic t_tx_ctrl;
    {mem[16'h1100], mem[16'h1101], mem[16'h2001], mem[16'h2002]} = 32'h85C10385;
    set_area(`BSM_MS_LO, 16'h10FF, 16'h1101);
    set_area(`BSM_CS_LO, 16'h2000, 16'h2002);
    start_io(8'h80, `BSM_CMD_TX);
    wait_irq(1'b1);
    `CHK("match", 8'h40, iob_status_o & 8'hC0)
    `CHK("scan", 16'h2001, rq[1])
    `CHK("scan end", 16'h2002, rq[2])
    cpu_rd(`BSM_CC_LO, rd);
    `CHK("list cur", 8'h02, rd)
    iob(2, 8'h00);
    `CHK("resume", 8'h00, iob_status_o & 8'hC0)
    wait_irq(1'b1);
    `CHK("tail", 16'h1101, rq[rq.size() - 1])
    `CHK("end", 1'b1, iob_status_o[`BSM_ST_NBUSY])
  endtask
  // EBCDIC: 05 is control and listed; stop aborts the suspended transfer.
  task automatic t_abort;
    {mem[16'h1100], mem[16'h2001]} = 16'h0505;
    set_area(`BSM_MS_LO, 16'h10FF, 16'h1104);
    set_area(`BSM_CS_LO, 16'h2000, 16'h2001);
    start_io(8'h00, `BSM_CMD_TX);
    wait_irq(1'b1);
    `CHK("match", 1'b1, iob_status_o[`BSM_ST_ACC])
    iob(3, 8'h00);
    `CHK("stop st", 8'h80, iob_status_o & 8'hC0)
    `CHK("stop irq", 1'b0, irq_o)
    `CHK("stop req", 1'b0, mem_req_o)
  endtask
  task automatic t_rx;
    set_area(`BSM_MS_LO, 16'h3000, 16'h3002);
    set_area(`BSM_CS_LO, 16'h2000, 16'h2000);
    rc = i_bsm_modem_model.rts_cycles;
    iob(0, 8'h01);
    iob(3, 8'h00);
    iob(4, 8'h00);
    rq.delete();
    wq.delete();
    // Bits count from the receive command on, so bit 0 leads the command by one clock.
    fork
      i_bsm_modem_model.send(16'h965A);
      begin
        @(negedge ref_clk_i);
        iob(1, `BSM_CMD_RX);
      end
    join
    wait_irq(1'b1);
    `CHK("stores", 2, wq.size())
    `CHK("store 1", 24'h30015A, wq[0])
    `CHK("store 2", 24'h300296, wq[1])
    `CHK("no send", rc, i_bsm_modem_model.rts_cycles)
    cpu_rd(`BSM_MC_LO, rd);
    `CHK("rx cur", 8'h02, rd)
  endtask
  task automatic t_unsel_halt;
    iob(0, 8'h01);
    iob(3, 8'h00);
    iob(0, 8'h02);
    iob(1, `BSM_CMD_TX);
    repeat (4) @(negedge ref_clk_i);
    `CHK("unsel st", 8'h80, iob_status_o & 8'hC0)
    `CHK("unsel req", 1'b0, mem_req_o)
    `CHK("unsel irq", 1'b0, irq_o)
    iob(0, 8'h01);
    iob(1, 8'h00);
    wait_irq(1'b1);
    `CHK("halt", 1'b1, iob_status_o[`BSM_ST_NBUSY])
  endtask

  initial begin
    {errors, n_tests, wt} = '0;
    {cpu_wr_i, iob_sel_i, iob_com1_i, iob_com2_i, iob_dvcl_i, iob_ofl_i} = '0;
    {cpu_addr_i, cpu_wdata_i, iob_data_i, iob_dev_i, mem_rdata_i} = '0;
    mem_gnt_i = 1'b0;
    rst_b_i = 1'b0;
    repeat (20) @(negedge ref_clk_i);
    rst_b_i = 1'b1;
    t_regs();
    t_tx_plain();
    t_tx_ctrl();
    t_abort();
    t_rx();
    t_unsel_halt();
    finish_test();
  end
endmodule
`default_nettype wire
